/* hw/spi_ctrl_pkg.sv */
package spi_ctrl_pkg;

  // ****************************************************
  // register byte addresses
  // ****************************************************
  localparam logic [4:0] ADDR_CTRL    = 5'h00;
  localparam logic [4:0] ADDR_SELECT  = 5'h04;
  localparam logic [4:0] ADDR_DIVIDER = 5'h08;
  localparam logic [4:0] ADDR_TX0     = 5'h0C;
  localparam logic [4:0] ADDR_TX1     = 5'h10;
  localparam logic [4:0] ADDR_RX0     = 5'h14;
  localparam logic [4:0] ADDR_RX1     = 5'h18;

  // ****************************************************
  // serial_control_reg fields
  // ****************************************************
  localparam int CTRL_GO_BIT        = 0;
  localparam int CTRL_LAUNCH_BIT    = 1;
  localparam int CTRL_CAPTURE_BIT   = 2;
  localparam int CTRL_WIDTH_LSB     = 3;
  localparam int CTRL_COUNT_LSB     = 8;
  localparam int CTRL_LSB_FIRST_BIT = 10;
  localparam int CTRL_IDLE_POL_BIT  = 11;
  localparam int CTRL_GAP_LSB       = 12;
  localparam int CTRL_DONE_BIT      = 16;
  localparam int CTRL_DONE_IEN_BIT  = 17;
  localparam int CTRL_SLAVE_BIT     = 18;
  localparam int CTRL_BYTE_REVERSE_ENABLE_BIT   = 19;
  localparam int CTRL_BYTE_GAP_BIT  = 20;
  localparam logic [31:0] CTRL_CFG_MASK = 32'h001E_FFFE;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;

  // ****************************************************
  // select_control_reg fields
  // ****************************************************
  localparam int SEL_LINES_LSB = 0;
  localparam int SEL_POL_BIT   = 2;
  localparam int SEL_AUTO_BIT  = 3;
  localparam int SEL_LEVEL_BIT = 4;
  localparam logic [31:0] SEL_MASK  = 32'h0000_001F;
  localparam logic [31:0] SEL_RESET = 32'h0000_0000;

  // ****************************************************
  // clock_divider_reg and timing
  // ****************************************************
  localparam logic [31:0] DIV_MASK  = 32'h0000_FFFF;
  localparam logic [31:0] DIV_RESET = 32'h0000_0000;
  localparam logic [5:0]  WORD_FULL      = 6'h20;
  localparam logic [5:0]  GAP_BASE       = 6'h02;
  localparam logic [1:0]  COUNT_TWO_WORD = 2'h1;

  typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_GAP} engine_state_e;

endpackage

/* hw/spi_master_slave_controller.sv */
`timescale 1ns/1ps
`default_nettype none

// Function
// - software role bit picks master or slave operation
// - master drives clock and selects; slave watches clock and first select, drives second select inactive
// - never more than one master select output active
// - polarity bit sets active level of select outputs and input
// - trigger bit picks level or edge handling of select
// - auto select asserts enabled lines during transfer, drops at end
// - manual select lines follow their software bits directly, the second only while the first bit is clear
// - divisor register sets master serial clock rate
// - master clock idles high when polarity bit one, else low
// - width field sets bits per word, zero means 32
// - count one sends two words, first then second
// - bit order zero sends msb first, one sends lsb first
// - launch bit zero changes data on rising edge, one falling
// - capture bit one samples on falling edge, zero rising
// - master gap between burst words is gap field plus two periods
// - gap runs between last edge and first edge of next word
// - gap resets zero; word gap in bursts, byte gap single 32-bit word
// - msb first with byte_reverse_enable sends least significant byte first
// - data reached only through 32-bit transmit and receive registers
// - finished transfer sets done flag, may interrupt, write one clears
module spi_master_slave_controller
  import spi_ctrl_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [4:0]  address_i,
  input  wire logic        read_i,
  input  wire logic        write_i,
  input  wire logic [31:0] writedata_i,
  input  wire logic [3:0]  byteenable_i,
  output logic      [31:0] readdata_o,
  output logic             waitrequest_o,
  output logic             done_irq_o,
  output logic             sclk_o,
  output logic             sclk_oe_n_o,
  input  wire logic        sclk_i,
  output logic             select_out_first_o,
  output logic             select_first_oe_n_o,
  input  wire logic        select_first_i,
  output logic             select_out_second_o,
  output logic             serial_out_o,
  output logic             serial_out_oe_n_o,
  input  wire logic        serial_in_i
);

  // ****************************************************
  // register storage and field decode
  // ****************************************************
  logic [31:0]   cfg_reg, sel_reg, div_reg, tx0_reg, tx1_reg;
  logic [31:0]   rx0_reg, rx1_reg, ctrl_view, ctrl_new;
  logic          busy_reg, done_flag_reg, ack_reg;
  logic          launch_neg, capture_neg, lsb_first, idle_pol;
  logic          slave_role, byte_reverse_enable, byte_gap_en, done_ien;
  logic          sel_pol, auto_sel, sel_level;
  logic [1:0]    sel_lines, count_f;
  logic [4:0]    width_f;
  logic [3:0]    gap_f;
  logic [5:0]    n_bits;
  logic          req, wr_en, wr_ctrl, go, done_pulse;
  engine_state_e state;

  assign launch_neg  = cfg_reg[CTRL_LAUNCH_BIT];
  assign capture_neg = cfg_reg[CTRL_CAPTURE_BIT];
  assign lsb_first   = cfg_reg[CTRL_LSB_FIRST_BIT];
  assign idle_pol    = cfg_reg[CTRL_IDLE_POL_BIT];
  assign slave_role  = cfg_reg[CTRL_SLAVE_BIT];
  assign byte_reverse_enable     = cfg_reg[CTRL_BYTE_REVERSE_ENABLE_BIT];
  assign byte_gap_en = cfg_reg[CTRL_BYTE_GAP_BIT];
  assign done_ien    = cfg_reg[CTRL_DONE_IEN_BIT];
  assign width_f     = cfg_reg[CTRL_WIDTH_LSB +: 5];
  assign count_f     = cfg_reg[CTRL_COUNT_LSB +: 2];
  assign gap_f       = cfg_reg[CTRL_GAP_LSB +: 4];
  assign sel_lines   = sel_reg[SEL_LINES_LSB +: 2];
  assign sel_pol     = sel_reg[SEL_POL_BIT];
  assign auto_sel    = sel_reg[SEL_AUTO_BIT];
  assign sel_level   = sel_reg[SEL_LEVEL_BIT];
  assign n_bits      = (width_f == 5'h00) ? WORD_FULL : {1'b0, width_f};

  function automatic logic [31:0] merge(input logic [31:0] old_v);
    merge = old_v;
    for (int b = 0; b < 4; b++) begin
      if (byteenable_i[b]) begin
        merge[b*8 +: 8] = writedata_i[b*8 +: 8];
      end
    end
  endfunction

  // bit position of the k-th serial bit inside a 32-bit word
  function automatic logic [4:0] bit_pos(input logic [5:0] k);
    logic [5:0] r;
    r = n_bits - 6'h01 - k;
    if (lsb_first) begin
      bit_pos = k[4:0];
    end else if (byte_reverse_enable) begin
      bit_pos = {k[4:3], ~k[2:0]};
    end else begin
      bit_pos = r[4:0];
    end
  endfunction

  // ****************************************************
  // avalon slave: one wait cycle per access
  // ****************************************************
  assign req           = read_i | write_i;
  assign waitrequest_o = req & ~ack_reg;
  assign wr_en         = write_i & ack_reg;
  assign wr_ctrl       = wr_en & (address_i[4:2] == ADDR_CTRL[4:2]);

  always_comb begin
    ctrl_view                = cfg_reg;
    ctrl_view[CTRL_GO_BIT]   = busy_reg;
    ctrl_view[CTRL_DONE_BIT] = done_flag_reg;
  end
  assign ctrl_new = merge(ctrl_view);
  assign go       = wr_ctrl & ~busy_reg & ctrl_new[CTRL_GO_BIT];

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req & ~ack_reg;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      readdata_o <= 32'h0000_0000;
    end else if (read_i & ~ack_reg) begin
      case (address_i[4:2])
        ADDR_CTRL[4:2]:    readdata_o <= ctrl_view;
        ADDR_SELECT[4:2]:  readdata_o <= sel_reg;
        ADDR_DIVIDER[4:2]: readdata_o <= div_reg;
        ADDR_TX0[4:2]:     readdata_o <= tx0_reg;
        ADDR_TX1[4:2]:     readdata_o <= tx1_reg;
        ADDR_RX0[4:2]:     readdata_o <= rx0_reg;
        ADDR_RX1[4:2]:     readdata_o <= rx1_reg;
        default:           readdata_o <= 32'h0000_0000;
      endcase
    end
  end

  // configuration is frozen while busy so a transfer never changes shape
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      cfg_reg <= CTRL_RESET;
      div_reg <= DIV_RESET;
      tx0_reg <= 32'h0000_0000;
      tx1_reg <= 32'h0000_0000;
    end else if (wr_en & ~busy_reg) begin
      case (address_i[4:2])
        ADDR_CTRL[4:2]:    cfg_reg <= ctrl_new & CTRL_CFG_MASK;
        ADDR_DIVIDER[4:2]: div_reg <= merge(div_reg) & DIV_MASK;
        ADDR_TX0[4:2]:     tx0_reg <= merge(tx0_reg);
        ADDR_TX1[4:2]:     tx1_reg <= merge(tx1_reg);
        default:           cfg_reg <= cfg_reg;
      endcase
    end
  end

  // select lines stay writable so manual select works around transfers
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      sel_reg <= SEL_RESET;
    end else if (wr_en & (address_i[4:2] == ADDR_SELECT[4:2])) begin
      sel_reg <= merge(sel_reg) & SEL_MASK;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      busy_reg <= 1'b0;
    end else if (done_pulse) begin
      busy_reg <= 1'b0;
    end else if (go) begin
      busy_reg <= 1'b1;
    end
  end

  // completion beats a write-one clear in the same cycle
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      done_flag_reg <= 1'b0;
    end else if (done_pulse) begin
      done_flag_reg <= 1'b1;
    end else if (wr_ctrl & byteenable_i[2] & writedata_i[CTRL_DONE_BIT]) begin
      done_flag_reg <= 1'b0;
    end
  end
  assign done_irq_o = done_flag_reg & done_ien;

  // ****************************************************
  // pin synchronisers and slave select detection
  // ****************************************************
  logic [2:0] pin_s1, pin_s2;
  logic       sclk_s3, sel_lvl, sel_prev_lvl, sel_latch, sel_active;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      pin_s1  <= 3'h0;
      pin_s2  <= 3'h0;
      sclk_s3 <= 1'b0;
    end else begin
      pin_s1  <= {sclk_i, select_first_i, serial_in_i};
      pin_s2  <= pin_s1;
      sclk_s3 <= pin_s2[2];
    end
  end

  assign sel_lvl = (pin_s2[1] == sel_pol);

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      sel_prev_lvl <= 1'b0;
      sel_latch    <= 1'b0;
    end else begin
      sel_prev_lvl <= sel_lvl;
      if (!sel_lvl) begin
        sel_latch <= 1'b0;
      end else if (!sel_prev_lvl) begin
        sel_latch <= 1'b1;
      end
    end
  end
  assign sel_active = sel_level ? sel_lvl : sel_latch;

  // ****************************************************
  // serial clock generation and edge events
  // ****************************************************
  logic [15:0] div_cnt;
  logic [5:0]  gap_cnt, gap_last;
  logic        sclk_level, tick, edge_ev, edge_rise, gap_done, in_gap;

  assign tick     = ~slave_role & (state != ST_IDLE)
                    & (div_cnt == div_reg[15:0]);
  assign edge_ev  = slave_role
                    ? ((state == ST_SHIFT) & sel_active
                       & (pin_s2[2] != sclk_s3))
                    : (tick & (state == ST_SHIFT));
  assign edge_rise = slave_role ? pin_s2[2] : ~sclk_level;
  // gap of (field + 2) periods counted in half periods, last edge to next
  assign gap_last = (({2'b00, gap_f} + GAP_BASE) << 1) - GAP_BASE;
  assign gap_done = (state == ST_GAP) & tick & (gap_cnt == gap_last);
  assign in_gap   = (state == ST_GAP);

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      div_cnt    <= 16'h0000;
      sclk_level <= 1'b0;
      gap_cnt    <= 6'h00;
    end else if (state == ST_IDLE) begin
      div_cnt    <= 16'h0000;
      sclk_level <= idle_pol;
      gap_cnt    <= 6'h00;
    end else begin
      div_cnt <= tick ? 16'h0000 : div_cnt + 16'h0001;
      if (edge_ev & ~slave_role) begin
        sclk_level <= ~sclk_level;
      end
      if (in_gap & tick) begin
        gap_cnt <= gap_cnt + 6'h01;
      end else if (!in_gap) begin
        gap_cnt <= 6'h00;
      end
    end
  end

  assign sclk_o      = sclk_level;
  assign sclk_oe_n_o = slave_role;

  // ****************************************************
  // shift engine
  // ****************************************************
  logic [6:0]  edge_cnt;
  logic [5:0]  bit_tx, bit_rx, bit_tx_inc;
  logic [31:0] tx_word, rx_shift, rx_shift_next;
  logic        word_idx, out_reg, is_launch, is_capture;
  logic        last_edge, word_next, byte_end;
  logic [4:0]  first_pos;

  assign is_launch  = edge_ev & (edge_rise != launch_neg);
  assign is_capture = edge_ev & (edge_rise != capture_neg);
  assign last_edge  = edge_ev & (edge_cnt == {n_bits, 1'b0} - 7'h01);
  assign word_next  = last_edge & ~word_idx
                      & (count_f == COUNT_TWO_WORD);
  assign done_pulse = last_edge & ~word_next;
  assign byte_end   = edge_ev & (edge_cnt[3:0] == 4'hF) & ~last_edge
                      & ~slave_role & (count_f == 2'h0) & byte_gap_en
                      & (n_bits == WORD_FULL);
  assign bit_tx_inc = bit_tx + 6'h01;
  // the go write may reshape the word, so bit 0 comes from the new fields
  assign first_pos  = ctrl_new[CTRL_LSB_FIRST_BIT] ? 5'h00
                      : ctrl_new[CTRL_BYTE_REVERSE_ENABLE_BIT] ? 5'h07
                      : ctrl_new[CTRL_WIDTH_LSB +: 5] - 5'h01;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: if (go) begin
          state <= ST_SHIFT;
        end
        ST_SHIFT: if (done_pulse) begin
          state <= ST_IDLE;
        end else if ((word_next | byte_end) & ~slave_role) begin
          state <= ST_GAP;
        end
        ST_GAP: if (gap_done) begin
          state <= ST_SHIFT;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // the first edge of a word never advances data: bit 0 is already out
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      edge_cnt <= 7'h00;
      bit_tx   <= 6'h00;
      bit_rx   <= 6'h00;
      word_idx <= 1'b0;
      tx_word  <= 32'h0000_0000;
      out_reg  <= 1'b0;
    end else if (go) begin
      edge_cnt <= 7'h00;
      bit_tx   <= 6'h00;
      bit_rx   <= 6'h00;
      word_idx <= 1'b0;
      tx_word  <= tx0_reg;
      out_reg  <= tx0_reg[first_pos];
    end else if (slave_role & (state == ST_SHIFT) & ~sel_active) begin
      edge_cnt <= 7'h00;
      bit_tx   <= 6'h00;
      bit_rx   <= 6'h00;
      out_reg  <= tx_word[bit_pos(6'h00)];
    end else if (word_next) begin
      edge_cnt <= 7'h00;
      bit_tx   <= 6'h00;
      bit_rx   <= 6'h00;
      word_idx <= 1'b1;
      tx_word  <= tx1_reg;
      out_reg  <= tx1_reg[bit_pos(6'h00)];
    end else if (edge_ev) begin
      edge_cnt <= edge_cnt + 7'h01;
      if (is_capture) begin
        bit_rx <= bit_rx + 6'h01;
      end
      if (is_launch && (edge_cnt != 7'h00) && (bit_tx_inc < n_bits)) begin
        bit_tx  <= bit_tx_inc;
        out_reg <= tx_word[bit_pos(bit_tx_inc)];
      end
    end
  end

  always_comb begin
    rx_shift_next = rx_shift;
    if (is_capture) begin
      rx_shift_next[bit_pos(bit_rx)] = pin_s2[0];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      rx_shift <= 32'h0000_0000;
      rx0_reg  <= 32'h0000_0000;
      rx1_reg  <= 32'h0000_0000;
    end else begin
      rx_shift <= (go | word_next) ? 32'h0000_0000 : rx_shift_next;
      if (last_edge & ~word_idx) begin
        rx0_reg <= rx_shift_next;
      end
      if (last_edge & word_idx) begin
        rx1_reg <= rx_shift_next;
      end
    end
  end

  assign serial_out_o      = out_reg;
  assign serial_out_oe_n_o = slave_role & ~((state == ST_SHIFT) & sel_active);

  // ****************************************************
  // select outputs
  // ****************************************************
  logic first_act, second_act;

  // the second line yields to the first so only one is ever active
  assign first_act  = ~slave_role & sel_lines[0]
                      & (~auto_sel | (state != ST_IDLE));
  assign second_act = ~slave_role & sel_lines[1] & ~sel_lines[0]
                      & (~auto_sel | (state != ST_IDLE));

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      select_out_first_o  <= 1'b1;
      select_out_second_o <= 1'b1;
    end else begin
      select_out_first_o  <= first_act ? sel_pol : ~sel_pol;
      select_out_second_o <= second_act ? sel_pol : ~sel_pol;
    end
  end
  assign select_first_oe_n_o = slave_role;

  // ****************************************************
  // checks
  // ****************************************************
  AST_ONE_SELECT: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    !(select_out_first_o == sel_pol && select_out_second_o == sel_pol
      && $past(sel_pol) == sel_pol && !slave_role))
    else $error("both select outputs active");

  AST_DONE_CLEARS_BUSY: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    done_pulse |=> !busy_reg && done_flag_reg && state == ST_IDLE)
    else $error("busy or flag wrong after completion");

  AST_SET_WINS: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    done_pulse && wr_ctrl && byteenable_i[2] && writedata_i[CTRL_DONE_BIT]
    |=> done_flag_reg)
    else $error("done flag lost to a clear");

  AST_IDLE_CLOCK: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    !slave_role && state == ST_IDLE ##1 state == ST_IDLE && $stable(idle_pol)
    |-> sclk_o == idle_pol)
    else $error("serial clock not at idle level");

  AST_MANUAL_SELECT: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    !slave_role && !auto_sel && sel_lines == 2'h1
    |=> select_out_first_o == $past(sel_pol))
    else $error("manual select does not follow its bit");

  AST_AUTO_RELEASE: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    !slave_role && auto_sel && done_pulse
    |-> ##2 (!$past(auto_sel) || select_out_first_o == !$past(sel_pol)))
    else $error("auto select not released after transfer");

  AST_DIVIDER_RATE: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    edge_ev && !slave_role && div_reg == 32'h0000_0003 && !last_edge
    && !byte_end |=> !edge_ev [*3] ##1 edge_ev)
    else $error("serial clock half period differs from divisor");

  AST_GAP_LENGTH: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    $rose(in_gap) && div_reg == 32'h0000_0003 && gap_f == 4'h1
    |-> ##19 gap_done ##4 (state == ST_SHIFT && edge_ev))
    else $error("word gap length wrong");

  AST_LSB_FIRST: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    $rose(state == ST_SHIFT) && lsb_first && !slave_role && !word_idx
    && $past(state) == ST_IDLE |-> serial_out_o == tx_word[0])
    else $error("first bit is not the least significant");

endmodule

`default_nettype wire

/* sim/spi_slave_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ****************************************************
// peripheral on the far side of the serial link
// ****************************************************
module spi_slave_model (
  input  wire logic        sclk_i,
  input  wire logic        sel_n_i,
  input  wire logic        mosi_i,
  input  wire logic [31:0] reply_i,
  output logic             miso_o
);
  logic [63:0] rx_bits;
  logic [31:0] tx_sh;
  logic        last;

  initial begin
    rx_bits = '0;
    tx_sh   = '0;
    last    = 1'b0;
  end

  // each selection starts a fresh capture and reloads the reply word
  always @(negedge sel_n_i) begin
    rx_bits = '0;
    tx_sh   = reply_i;
  end

  always @(posedge sel_n_i) begin
    last = tx_sh[31];
  end

  // capture on rising, launch on falling, as the bench programs the device
  always @(posedge sclk_i) begin
    if (!sel_n_i) rx_bits <= {rx_bits[62:0], mosi_i};
  end

  always @(negedge sclk_i) begin
    if (!sel_n_i) tx_sh <= {tx_sh[30:0], 1'b0};
  end

  // a released line shows the inverse, so a stale bit never passes
  assign miso_o = sel_n_i ? ~last : tx_sh[31];
endmodule

`default_nettype wire

/* sim/testbench.sv */
`timescale 1ns/1ps
`default_nettype none

// ****************************************************
// register-level tests of the serial controller
// ****************************************************
module testbench;
  import spi_ctrl_pkg::*;
  logic        sys_clk_i   = 1'b0;
  logic        rst_n_i     = 1'b0;
  logic [4:0]  address_i   = 5'h00;
  logic        read_i      = 1'b0;
  logic        write_i     = 1'b0;
  logic [31:0] writedata_i = 32'h0000_0000;
  logic [31:0] readdata_o, q;
  logic        waitrequest_o, done_irq_o, sclk_o, serial_out_o, miso;
  logic        select_out_first_o, select_out_second_o;
  logic        sclk_q      = 1'b0;
  logic        sel_q       = 1'b1;
  logic        sec_seen    = 1'b0;
  logic        ext_sclk    = 1'b0;
  logic        ext_sel_n   = 1'b1;
  int          hp_cnt      = 0;
  int          half_max    = 0;
  int          mismatches  = 0;
  int          tests_run   = 0;
  logic [4:0]  r_addr [4] = '{ADDR_CTRL, ADDR_SELECT, ADDR_DIVIDER, 5'h1C};
  logic [31:0] s_val [4]  = '{32'h0000_0001, 32'h0000_0002,
                              32'h0000_0005, 32'h0000_0006};
  logic [1:0]  s_exp [4]  = '{2'b01, 2'b10, 2'b10, 2'b01};
  logic [31:0] t_ctl [4]  = '{32'h0002_0043, 32'h0002_0443,
                              32'h0002_1143, 32'h000A_0003};
  logic [31:0] t_tx0 [4]  = '{32'h0000_005A, 32'h0000_0001,
                              32'h0000_0011, 32'h0403_0201};
  logic [63:0] t_bits [4] = '{64'h5A, 64'h80, 64'h1122, 64'h0102_0304};
  logic [31:0] t_mask [4] = '{32'hFF, 32'hFF, 32'hFF, 32'hFFFF_FFFF};
  logic [31:0] t_rx0 [4]  = '{32'hC3, 32'hC3, 32'hC3, 32'h3C5A_A5C3};
  logic [31:0] t_rx1 [4]  = '{32'h0000_0000, 32'h0000_0000,
                              32'h0000_00A5, 32'h0000_00A5};
  int          t_half [4] = '{4, 4, 24, 4};

  always #5 sys_clk_i = ~sys_clk_i;

  spi_master_slave_controller DUT (
    .sys_clk_i           (sys_clk_i),
    .rst_n_i             (rst_n_i),
    .address_i           (address_i),
    .read_i              (read_i),
    .write_i             (write_i),
    .writedata_i         (writedata_i),
    .byteenable_i        (4'hF),
    .readdata_o          (readdata_o),
    .waitrequest_o       (waitrequest_o),
    .done_irq_o          (done_irq_o),
    .sclk_o              (sclk_o),
    .sclk_oe_n_o         (),
    .sclk_i              (ext_sclk),
    .select_out_first_o  (select_out_first_o),
    .select_first_oe_n_o (),
    .select_first_i      (ext_sel_n),
    .select_out_second_o (select_out_second_o),
    .serial_out_o        (serial_out_o),
    .serial_out_oe_n_o   (),
    .serial_in_i         (ext_sel_n ? miso : serial_out_o)
  );

  spi_slave_model peer (
    .sclk_i  (sclk_o),
    .sel_n_i (select_out_first_o),
    .mosi_i  (serial_out_o),
    .reply_i (32'hC3A5_5A3C),
    .miso_o  (miso)
  );

  // longest clock half period seen while the first line is selected
  always @(posedge sys_clk_i) begin
    sclk_q <= sclk_o;
    sel_q  <= select_out_first_o;
    hp_cnt <= (sclk_o != sclk_q || select_out_first_o) ? 1 : hp_cnt + 1;
    if (sel_q && !select_out_first_o) begin
      half_max <= 0;
      sec_seen <= 1'b0;
    end else if (!select_out_first_o) begin
      if (sclk_o != sclk_q && hp_cnt > half_max) half_max <= hp_cnt;
      if (!select_out_second_o) sec_seen <= 1'b1;
    end
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    if (mismatches == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    address_i   <= a;
    writedata_i <= d;
    write_i     <= wr;
    read_i      <= !wr;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (waitrequest_o !== 1'b0 && n < 20);
    q = readdata_o;
    read_i  <= 1'b0;
    write_i <= 1'b0;
    if (waitrequest_o !== 1'b0) begin
      mismatches++;
      give_verdict();
    end
    @(posedge sys_clk_i);
  endtask

  // start with the go bit, then poll busy until it drops
  task automatic xfer(input logic [31:0] ctl);
    int n;
    n = 0;
    bus(1'b1, ADDR_CTRL, ctl);
    do begin
      bus(1'b0, ADDR_CTRL, 32'h0000_0000);
      n++;
    end while (q[CTRL_GO_BIT] !== 1'b0 && n < 400);
    if (q[CTRL_GO_BIT] !== 1'b0) begin
      mismatches++;
      give_verdict();
    end
  endtask

  initial begin
    repeat (8) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    @(posedge sys_clk_i);
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, r_addr[i], 32'h0000_0000);
      chk(q, 32'h0000_0000);
    end
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, ADDR_SELECT, s_val[i]);
      @(posedge sys_clk_i);
      chk({select_out_first_o, select_out_second_o}, s_exp[i]);
    end
    bus(1'b1, ADDR_CTRL, 32'h0000_0800);
    @(posedge sys_clk_i);
    chk(sclk_o, 1'b1);
    bus(1'b1, ADDR_CTRL, 32'h0000_0000);
    @(posedge sys_clk_i);
    chk(sclk_o, 1'b0);
    bus(1'b1, ADDR_DIVIDER, 32'h0000_0003);
    bus(1'b1, ADDR_SELECT, 32'h0000_0009);
    // launch falling and capture rising keeps the standard pairing
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, ADDR_TX0, t_tx0[i]);
      bus(1'b1, ADDR_TX1, 32'h0000_0022);
      xfer(t_ctl[i]);
      chk(peer.rx_bits, t_bits[i]);
      chk(half_max, t_half[i]);
      bus(1'b0, ADDR_RX0, 32'h0000_0000);
      chk(q & t_mask[i], t_rx0[i]);
      bus(1'b0, ADDR_RX1, 32'h0000_0000);
      chk(q & t_mask[i], t_rx1[i]);
      chk({done_irq_o, select_out_first_o, sec_seen}, 3'b110);
      // keep the irq enable so only the flag clear can drop the interrupt
      bus(1'b1, ADDR_CTRL, 32'h0003_0000);
      chk(done_irq_o, 1'b0);
    end
    // slave role: the bench plays the external master, data looped back
    bus(1'b1, ADDR_SELECT, 32'h0000_0010);
    bus(1'b1, ADDR_TX0, 32'h0000_00A6);
    bus(1'b1, ADDR_CTRL, 32'h0004_0043);
    ext_sel_n <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    for (int i = 0; i < 16; i++) begin
      ext_sclk <= ~ext_sclk;
      repeat (4) @(posedge sys_clk_i);
    end
    ext_sel_n <= 1'b1;
    bus(1'b0, ADDR_CTRL, 32'h0000_0000);
    chk(q, 32'h0005_0042);
    bus(1'b0, ADDR_RX0, 32'h0000_0000);
    chk(q, 32'h0000_00A6);
    give_verdict();
  end
endmodule

`default_nettype wire
